// ===== pkg/spi_mode_supply_regs.vh
// Constants for the serial mode and supply control block.
// Assumes inclusion by bare name from logic/ files.
`ifndef SPI_MODE_SUPPLY_REGS_VH
`define SPI_MODE_SUPPLY_REGS_VH

// Frame layout
`define FRAME_BITS 16
`define ACCESS_BIT 7
`define DATA_LSB 8

// Register address, 7-bit
`define MSC_ADDR 7'h01

// Field positions in mode_supply_control
`define MODE_HI 7
`define MODE_LO 6
`define THIRD_EN_BIT 5
`define SEC_HI 4
`define SEC_LO 3
`define OV_RST_BIT 2
`define RT_HI 1
`define RT_LO 0

// Reset and restart values
`define MSC_RESET 8'h00
`define MSC_RESTART_KEEP 8'h23
`define MSC_RESTART_SET 8'h00

// Mode encodings
`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h1
`define MODE_STOP 2'h2
`define MODE_SOFT_RESET 2'h3

// Second regulator policy encodings
`define SEC_OFF 2'h0
`define SEC_NORMAL 2'h1
`define SEC_NORMAL_STOP 2'h2
`define SEC_ALWAYS 2'h3

// Reset output low time after soft reset
`define CLK_PERIOD_NS 100
`define RO_LOW_NS 2000
`define RO_LOW_CYCLES (`RO_LOW_NS / `CLK_PERIOD_NS)

`endif

// ===== logic/spi_frame_engine.v
// Serial frame engine: LSB-first, 16-bit frames, data on rising clock edge.
// Assumes serial pins are already synchronous to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none
`include "spi_mode_supply_regs.vh"

module spi_frame_engine (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire spi_clk_in,
  input wire spi_cs_n_in,
  input wire spi_mosi_in,
  input wire [7:0] tx_byte_in,
  output reg addr_valid_out,
  output reg [7:0] addr_byte_out,
  output reg frame_valid_out,
  output reg frame_error_out,
  output reg [15:0] frame_out,
  output reg spi_miso_out,
  output wire spi_miso_oe_out
);

  reg sclk_q_r;
  reg cs_n_q_r;
  reg [4:0] bit_cnt_r;
  reg [15:0] shift_r;
  reg [7:0] tx_r;
  wire rise;
  wire fall;
  wire cs_end;

  assign rise = spi_clk_in & ~sclk_q_r & ~spi_cs_n_in;
  assign fall = ~spi_clk_in & sclk_q_r & ~spi_cs_n_in;
  assign cs_end = spi_cs_n_in & ~cs_n_q_r;
  assign spi_miso_oe_out = ~spi_cs_n_in;

  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      sclk_q_r <= 1'b0;
      cs_n_q_r <= 1'b1;
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      tx_r <= 8'h00;
      spi_miso_out <= 1'b0;
      addr_valid_out <= 1'b0;
      addr_byte_out <= 8'h00;
      frame_valid_out <= 1'b0;
      frame_error_out <= 1'b0;
      frame_out <= 16'h0000;
    end else begin
      sclk_q_r <= spi_clk_in;
      cs_n_q_r <= spi_cs_n_in;
      addr_valid_out <= 1'b0;
      frame_valid_out <= 1'b0;
      frame_error_out <= 1'b0;
      if (spi_cs_n_in) begin
        bit_cnt_r <= 5'h00;
        spi_miso_out <= 1'b0;
      end
      if (rise) begin
        shift_r <= {spi_mosi_in, shift_r[15:1]};
        // Saturate past 16 so an overlong frame stays invalid
        if (bit_cnt_r <= 5'h10)
          bit_cnt_r <= bit_cnt_r + 5'h01;
        if (bit_cnt_r == 5'h07) begin
          addr_byte_out <= {spi_mosi_in, shift_r[15:9]};
          addr_valid_out <= 1'b1;
        end
      end
      // Byte for the data phase is taken after the address is known
      if (fall && bit_cnt_r == 5'h08) begin
        spi_miso_out <= tx_byte_in[0];
        tx_r <= {1'b0, tx_byte_in[7:1]};
      end else if (fall && bit_cnt_r > 5'h08) begin
        spi_miso_out <= tx_r[0];
        tx_r <= {1'b0, tx_r[7:1]};
      end
      if (cs_end) begin
        if (bit_cnt_r == `FRAME_BITS) begin // R01
          frame_valid_out <= 1'b1;
          frame_out <= shift_r;
        end else if (bit_cnt_r != 5'h00) begin
          frame_error_out <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/spi_mode_supply_control_regs.v
// Mode and supply control register behind the serial control port.
// Assumes a host that frames with chip select and obeys the frame layout;
// restart, overtemperature and overvoltage events come from device logic.
`timescale 1ns/1ps
`default_nettype none
`include "spi_mode_supply_regs.vh"

// Summary of operation
// R01: Frames are exactly sixteen bits, two bytes
// R02: First byte: 7-bit address plus access bit
// R03: Bit 7 clear reads without modifying
// R04: Bit 7 set writes whole data byte
// R05: Data bits map to frame bits 8-15
// R06: Reserved bits read zero, host writes zero
// R07: Reset loads reset value, restart loads restart
// R08: Only hardware-modifiable bits change by logic
// R09: Mode field; code 11 is soft reset
// R10: Bit 5 enables third regulator
// R11: Bits 4:3 set second regulator policy
// R12: Bit 2 lets overvoltage cause restart
// R13: Bits 1:0 select main reset threshold
// R14: Reset all zero, restart keeps 5,1:0
// R15: Stop to sleep request is refused
// R16: Restart rewrites mode field to normal
// R17: Restart or overtemperature switches second regulator off
// R18: Write returns previous register content
// R19: Hardware update beats host write
module spi_mode_supply_control_regs #(
  parameter RO_LOW_CYCLES = `RO_LOW_CYCLES
) (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire spi_clk_in,
  input wire spi_cs_n_in,
  input wire spi_mosi_in,
  output wire spi_miso_out,
  output wire spi_miso_oe_out,
  input wire restart_event_in,
  input wire overtemp_event_in,
  input wire main_overvoltage_event_in,
  input wire main_overvoltage_flag_clear_in,
  input wire fail_safe_active_in,
  input wire soft_reset_output_config_in,
  output wire [1:0] sbc_mode_out,
  output wire third_regulator_enable_out,
  output wire [1:0] second_regulator_policy_out,
  output reg second_regulator_on_out,
  output wire main_overvoltage_restart_enable_out,
  output wire [1:0] main_reset_threshold_select_out,
  output reg main_overvoltage_flag_out,
  output reg overvoltage_restart_request_out,
  output reg soft_reset_pulse_out,
  output reg reset_output_pin_n_out,
  output reg mode_change_refused_out,
  output reg frame_error_out
);

  // Second regulator policy decode, used for the live output
  function sec_on;
    input [1:0] policy;
    input [1:0] mode;
    input fail_safe;
    begin
      case (policy)
        `SEC_OFF: sec_on = 1'b0;
        `SEC_NORMAL: sec_on = (mode == `MODE_NORMAL);
        `SEC_NORMAL_STOP: sec_on = (mode == `MODE_NORMAL) ||
                                   (mode == `MODE_STOP);
        `SEC_ALWAYS: sec_on = ~fail_safe;
        default: sec_on = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] msc_r;
  reg [7:0] msc_nxt;
  reg [15:0] ro_cnt_r;
  reg [15:0] ro_cnt_nxt;
  reg refused_nxt;
  reg soft_reset_nxt;

  wire addr_valid;
  wire [7:0] addr_byte;
  wire frame_valid;
  wire frame_bad;
  wire [15:0] frame;
  wire [7:0] tx_byte;
  wire [6:0] frame_addr;
  wire frame_write;
  wire [7:0] frame_data;
  wire msc_hit;
  wire [1:0] wr_mode;

  spi_frame_engine u_engine (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .spi_clk_in(spi_clk_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_mosi_in(spi_mosi_in),
    .tx_byte_in(tx_byte),
    .addr_valid_out(addr_valid),
    .addr_byte_out(addr_byte),
    .frame_valid_out(frame_valid),
    .frame_error_out(frame_bad),
    .frame_out(frame),
    .spi_miso_out(spi_miso_out),
    .spi_miso_oe_out(spi_miso_oe_out)
  );

  // Answer byte is chosen from the address byte before the write lands,
  // so a write returns what was programmed before it.
  assign tx_byte = (addr_byte[6:0] == `MSC_ADDR) ? msc_r : 8'h00; // R18 R06

  assign frame_addr = frame[6:0]; // R02
  assign frame_write = frame[`ACCESS_BIT]; // R03 R04
  assign frame_data = frame[15:`DATA_LSB]; // R05
  assign msc_hit = frame_valid && (frame_addr == `MSC_ADDR);
  assign wr_mode = frame_data[`MODE_HI:`MODE_LO];

  assign sbc_mode_out = msc_r[`MODE_HI:`MODE_LO]; // R09
  assign third_regulator_enable_out = msc_r[`THIRD_EN_BIT]; // R10
  assign second_regulator_policy_out = msc_r[`SEC_HI:`SEC_LO]; // R11
  assign main_overvoltage_restart_enable_out = msc_r[`OV_RST_BIT];
  assign main_reset_threshold_select_out = msc_r[`RT_HI:`RT_LO]; // R13

  always @* begin
    msc_nxt = msc_r;
    refused_nxt = 1'b0;
    soft_reset_nxt = 1'b0;
    // Host write, whole byte at once; reads leave the register alone
    if (msc_hit && frame_write) begin // R04 R03
      msc_nxt = frame_data;
      if (wr_mode == `MODE_SOFT_RESET) begin // R09
        soft_reset_nxt = 1'b1;
        msc_nxt = `MSC_RESET; // R07
      end else if (msc_r[`MODE_HI:`MODE_LO] == `MODE_STOP &&
                   wr_mode == `MODE_SLEEP) begin // R15
        // Other fields still take the written value
        msc_nxt[`MODE_HI:`MODE_LO] = `MODE_STOP;
        refused_nxt = 1'b1;
      end
    end
    // Hardware updates win over the host; restart acts on the prior content
    if (overtemp_event_in)
      msc_nxt[`SEC_HI:`SEC_LO] = `SEC_OFF; // R17 R19 R08
    if (restart_event_in) begin
      msc_nxt = (msc_r & `MSC_RESTART_KEEP) | `MSC_RESTART_SET; // R07 R14 R19
      msc_nxt[`MODE_HI:`MODE_LO] = `MODE_NORMAL; // R16
      msc_nxt[`SEC_HI:`SEC_LO] = `SEC_OFF; // R17
      soft_reset_nxt = 1'b0;
      refused_nxt = 1'b0;
    end
  end

  always @* begin
    ro_cnt_nxt = ro_cnt_r;
    if (soft_reset_nxt && !soft_reset_output_config_in)
      ro_cnt_nxt = RO_LOW_CYCLES[15:0]; // R09
    else if (ro_cnt_r != 16'h0000)
      ro_cnt_nxt = ro_cnt_r - 16'h0001;
  end

  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      msc_r <= `MSC_RESET; // R14
      ro_cnt_r <= 16'h0000;
      soft_reset_pulse_out <= 1'b0;
      mode_change_refused_out <= 1'b0;
      frame_error_out <= 1'b0;
      reset_output_pin_n_out <= 1'b1;
      second_regulator_on_out <= 1'b0;
    end else begin
      msc_r <= msc_nxt;
      ro_cnt_r <= ro_cnt_nxt;
      soft_reset_pulse_out <= soft_reset_nxt;
      mode_change_refused_out <= refused_nxt;
      frame_error_out <= frame_bad; // R01
      // Pin is low while the pulse counter runs
      reset_output_pin_n_out <= (ro_cnt_nxt == 16'h0000);
      second_regulator_on_out <= sec_on(msc_nxt[`SEC_HI:`SEC_LO],
                                        msc_nxt[`MODE_HI:`MODE_LO],
                                        fail_safe_active_in); // R11
    end
  end

  // Overvoltage flag: a new event beats a clear in the same cycle
  always @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      main_overvoltage_flag_out <= 1'b0;
      overvoltage_restart_request_out <= 1'b0;
    end else begin
      if (main_overvoltage_event_in)
        main_overvoltage_flag_out <= 1'b1; // R12
      else if (main_overvoltage_flag_clear_in)
        main_overvoltage_flag_out <= 1'b0;
      overvoltage_restart_request_out <= main_overvoltage_event_in &
                                         msc_r[`OV_RST_BIT]; // R12
    end
  end

endmodule
`default_nettype wire

// ===== bench/msc_props.sv
// Port checker for the mode and supply control register.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module msc_props (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic spi_cs_n_in,
  input wire logic restart_event_in,
  input wire logic overtemp_event_in,
  input wire logic main_overvoltage_event_in,
  input wire logic soft_reset_output_config_in,
  input wire logic [1:0] sbc_mode_out,
  input wire logic third_regulator_enable_out,
  input wire logic [1:0] second_regulator_policy_out,
  input wire logic main_overvoltage_restart_enable_out,
  input wire logic [1:0] main_reset_threshold_select_out,
  input wire logic main_overvoltage_flag_out,
  input wire logic overvoltage_restart_request_out,
  input wire logic soft_reset_pulse_out,
  input wire logic reset_output_pin_n_out,
  input wire logic mode_change_refused_out,
  input wire logic frame_error_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_soft_rst;
    $rose(soft_reset_pulse_out) && !soft_reset_output_config_in;
  endsequence
  chk_reset_clears: assert property (disable iff (1'b0) !reset_n_in |=> sbc_mode_out == 2'h0 &&
    main_reset_threshold_select_out == 2'h0 && reset_output_pin_n_out) else $error("reset value wrong");
  chk_restart_mode_normal: assert property (restart_event_in |=> sbc_mode_out == 2'h0) else $error("mode kept");
  chk_restart_sec_off: assert property (restart_event_in |=> second_regulator_policy_out == 2'h0)
    else $error("second regulator kept on restart");
  chk_overtemp_sec_off: assert property (overtemp_event_in |=> second_regulator_policy_out == 2'h0)
    else $error("second regulator kept on overtemp");
  chk_restart_keeps_bits: assert property (restart_event_in |=> !main_overvoltage_restart_enable_out &&
    $stable(third_regulator_enable_out) && $stable(main_reset_threshold_select_out)) else $error("restart value");
  chk_ov_flag_set: assert property (main_overvoltage_event_in |=> main_overvoltage_flag_out)
    else $error("overvoltage flag not set");
  chk_ov_restart_req: assert property (main_overvoltage_event_in && main_overvoltage_restart_enable_out
    |=> overvoltage_restart_request_out) else $error("no restart request");
  chk_thr_host_only: assert property ($changed(main_reset_threshold_select_out) |-> $past(spi_cs_n_in, 2))
    else $error("threshold changed without frame");
  chk_soft_reset_pin: assert property (s_soft_rst |-> ##[0:2] !reset_output_pin_n_out)
    else $error("reset pin not pulsed");
  chk_soft_reset_quiet: assert property ($rose(soft_reset_pulse_out) && soft_reset_output_config_in
    |-> reset_output_pin_n_out) else $error("reset pin pulsed while configured off");
  chk_stop_sleep_refused: assert property (mode_change_refused_out |-> sbc_mode_out == 2'h2)
    else $error("refused while not in stop");
  chk_frame_err_pulse: assert property (frame_error_out |=> !frame_error_out)
    else $error("frame error longer than a cycle");
endmodule
bind spi_mode_supply_control_regs msc_props u_msc_props (.*);
`default_nettype wire

// ===== bench/host_spi_master.sv
// Host serial master model: mode 0, LSB first, three clk per phase.
// Assumes the bench calls xfer; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_spi_master (
  input wire logic clk_sys_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_out,
  output logic spi_clk_in,
  output logic spi_cs_n_in,
  output logic spi_mosi_in
);
  // Output enable as seen at the first serial rising edge of the last frame
  logic oe_seen = 1'b0;
  initial begin
    spi_clk_in = 1'b0;
    spi_cs_n_in = 1'b1;
    spi_mosi_in = 1'b0;
  end
  // Lengths other than 16 only to provoke a frame error
  task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge clk_sys_in) spi_cs_n_in <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      spi_mosi_in <= f[i];
      repeat (3) @(posedge clk_sys_in);
      spi_clk_in <= 1'b1;
      if (i == 0) oe_seen = spi_miso_oe_out;
      if (i >= 8) rx[i-8] = spi_miso_out;
      repeat (3) @(posedge clk_sys_in);
      spi_clk_in <= 1'b0;
    end
    repeat (3) @(posedge clk_sys_in);
    spi_cs_n_in <= 1'b1;
    // Released line must not show the last bit
    spi_mosi_in <= ~spi_mosi_in;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// ===== bench/spi_mode_supply_control_regs_tb_top.sv
// Bench for the mode and supply control register.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module spi_mode_supply_control_regs_tb_top;
  logic clk_sys_in, reset_n_in, restart_event_in, overtemp_event_in, main_overvoltage_event_in;
  logic main_overvoltage_flag_clear_in, fail_safe_active_in, soft_reset_output_config_in;
  wire spi_clk_in, spi_cs_n_in, spi_mosi_in, spi_miso_out, spi_miso_oe_out, third_regulator_enable_out;
  wire second_regulator_on_out, main_overvoltage_restart_enable_out, main_overvoltage_flag_out;
  wire overvoltage_restart_request_out, soft_reset_pulse_out, reset_output_pin_n_out;
  wire mode_change_refused_out, frame_error_out;
  wire [1:0] sbc_mode_out, second_regulator_policy_out, main_reset_threshold_select_out;
  wire [7:0] regv = {sbc_mode_out, third_regulator_enable_out, second_regulator_policy_out,
    main_overvoltage_restart_enable_out, main_reset_threshold_select_out};
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] o;
  spi_mode_supply_control_regs #(.RO_LOW_CYCLES(3)) u_spi_mode_supply_control_regs (.*);
  host_spi_master u_host_spi_master (.*);
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d, output logic [7:0] old);
    u_host_spi_master.xfer({d, 1'b1, 7'h01}, 16, old);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    u_host_spi_master.xfer({8'hFF, 1'b0, a}, 16, v);
  endtask
  task automatic hit(input int w);
    @(posedge clk_sys_in) {restart_event_in, overtemp_event_in, main_overvoltage_event_in,
      main_overvoltage_flag_clear_in} <= 4'(w);
    @(posedge clk_sys_in) {restart_event_in, overtemp_event_in, main_overvoltage_event_in,
      main_overvoltage_flag_clear_in} <= 4'h0;
    @(posedge clk_sys_in);
  endtask
  task automatic t_access;
    chk("reset reg", 8'h00, regv);
    for (int k = 0; k < 4; k++) begin
      wr({3'b001, 2'(k), 1'b0, 2'(k)}, o);
      chk("fields", {3'b001, 2'(k), 1'b0, 2'(k)}, regv);
      chk("sec on", {7'h00, (k != 0)}, {7'h00, second_regulator_on_out});
    end
    wr(8'h3D, o);
    chk("old on write", 8'h3B, o);
    rd(7'h01, o);
    chk("read back", 8'h3D, o);
    chk("read no change", 8'h3D, regv);
    rd(7'h02, o);
    chk("unmapped read", 8'h00, o);
    chk("oe in frame", 8'h01, {7'h00, u_host_spi_master.oe_seen});
    chk("oe idle", 8'h00, {7'h00, spi_miso_oe_out});
  endtask
  task automatic t_modes;
    wr(8'h5D, o);
    chk("sleep", 8'h5D, regv);
    wr(8'h9D, o);
    chk("stop", 8'h9D, regv);
    chk("sec on stop", 8'h01, {7'h00, second_regulator_on_out});
    wr(8'h8D, o);
    chk("old on write 2", 8'h9D, o);
    chk("sec normal only", 8'h00, {7'h00, second_regulator_on_out});
    wr(8'h95, o);
    chk("sec normal stop", 8'h01, {7'h00, second_regulator_on_out});
    wr(8'h59, o);
    chk("stop to sleep", 8'h99, regv);
    u_host_spi_master.xfer(16'h4081, 15, o);
    chk("short frame", 8'h99, regv);
  endtask
  task automatic t_hw;
    wr(8'h3E, o);
    chk("sec on normal", 8'h01, {7'h00, second_regulator_on_out});
    fail_safe_active_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("sec off fail-safe", 8'h00, {7'h00, second_regulator_on_out});
    fail_safe_active_in <= 1'b0;
    hit(2);
    chk("ov flag", 8'h01, {7'h00, main_overvoltage_flag_out});
    hit(1);
    chk("ov clear", 8'h00, {7'h00, main_overvoltage_flag_out});
    hit(4);
    chk("overtemp", 8'h26, regv);
    chk("sec off overtemp", 8'h00, {7'h00, second_regulator_on_out});
    wr(8'hBE, o);
    hit(8);
    chk("restart", 8'h22, regv);
    wr(8'hC0, o);
    chk("soft reset", 8'h00, regv);
    chk("pin pulsed", 8'h00, {7'h00, reset_output_pin_n_out});
    // Second soft reset with the pin pulse switched off
    soft_reset_output_config_in <= 1'b1;
    wr(8'hC0, o);
    chk("soft reset quiet", 8'h00, regv);
    chk("pin held", 8'h01, {7'h00, reset_output_pin_n_out});
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    {restart_event_in, overtemp_event_in, main_overvoltage_event_in} = 3'h0;
    {main_overvoltage_flag_clear_in, fail_safe_active_in, soft_reset_output_config_in} = 3'h0;
    reset_n_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_access();
    t_modes();
    t_hw();
    close_out();
  end
endmodule
`default_nettype wire
